// ---- hw/spg_guard.sv ----
// Purpose: access guard for the serial programming and debug port
// Assumes: flash image bytes live here, programmed over apb
// Notes: programming only clears bits, erase sets whole image to ones
// Behaviour
// R1: both keys erase keyword: erase user flash
// R2: received erase, stored other: erase unless protected
// R3: stored erase, received other: mismatch, refuse
// R4: stored lockout keyword refuses all port communication
// R5: lockout plus protection blocks every programmer
// R6: option bit0 low starts watchdog after reset
// R7: option bit2 low disables protection outright
// R8: protection active only when bit3 low, bit2 high
// R9: bits 5..4 pick shared voltage detect level
// R10: bit6 low enables voltage monitor and power-on reset
// R11: bit7 low enables count source protection
// R12: erase returns option byte to all ones
// R13: programmer must not reprogram without erase
// R14: options fetched from two fixed flash bytes; outputs here are captured from the SL_OPT byte only
// R15: blank reset vector skips key check, accepts; code still refuses when the stored key is the lockout keyword
// R16: key mismatch refuses every command; code still erases on a received erase keyword when protection is off (R2)
// R17: keywords need all seven stored bytes matching
// R18: keys compared byte by byte, all must agree
`timescale 1ns/10ps
module spg_guard import spg_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flash_init,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic serial_access_grant,
  output logic serial_refused,
  output logic user_flash_erase,
  output logic parallel_prog_block,
  output logic wdt_autostart,
  output logic count_src_protect_en,
  output logic vmon_reset_en,
  output logic por_en,
  output logic [1:0] vdet_level,
  output logic code_protect_en
);
  logic [7:0] flash_r [N_SLOTS];
  logic [KEY_W-1:0] rx_key_r;
  logic [KEY_W-1:0] st_key;
  spg_state_t state_r;
  logic [31:0] prdata_r, rd_nxt;
  logic pready_r, pslverr_r, hit_nxt;
  logic [15:0] idx;
  logic [3:0] slot;
  logic setup, wr, ctrl_wr, start_req, cmp_start;
  logic cmp_done, cmp_match, rx_erase, st_erase, st_lock;
  logic granted_r, refused_r, lock_r, erased_r, match_r, ovp_r, par_block_r;
  logic erase_pulse_r, cap_pend_r;
  logic wdt_auto_r, csp_r, vmon_r, por_r, prot_r;
  logic [1:0] vdet_r;
  logic blank_vec, prot_live, go_erase;
  logic [1:0] prot_pair;

  assign idx = paddr[APB_AW-1:2];
  assign slot = slot_of(idx);
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready_r & pwrite;
  assign ctrl_wr = wr && (idx == IDX_CTRL) && pstrb[0];
  assign start_req = ctrl_wr && pwdata[CTRL_START];
  assign cmp_start = start_req && (state_r == ST_IDLE);

  always_comb begin
    st_key = '0;
    for (int i = 0; i < KEY_BYTES; i++) begin
      st_key[i*8 +: 8] = flash_r[i];
    end
  end

  assign blank_vec = (flash_r[SL_RVEC0] & flash_r[SL_RVEC1] & flash_r[SL_RVEC2])
    == ERASED_BYTE; // see R15
  assign prot_pair = {flash_r[SL_OPT][OPT_PROT_N], flash_r[SL_OPT][OPT_PROT_DIS]};
  assign prot_live = (prot_pair == PROT_ENABLED_PAIR); // see R7, R8
  assign go_erase = !st_lock && !blank_vec && rx_erase
    && (st_erase || !prot_live); // see R1, R2

  spg_key_cmp #(.NBYTES(KEY_BYTES)) u_cmp (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(cmp_start),
    .rx_key(rx_key_r),
    .st_key(st_key),
    .done_r(cmp_done),
    .match_r(cmp_match),
    .rx_erase_r(rx_erase),
    .st_erase_r(st_erase),
    .st_lock_r(st_lock)
  );

  // apb: no wait state, answer computed in setup
  always_comb begin
    rd_nxt = '0;
    hit_nxt = 1'b1;
    case (idx)
      IDX_CTRL: rd_nxt = '0;
      IDX_STATUS: begin
        rd_nxt[STS_BUSY] = (state_r != ST_IDLE);
        rd_nxt[STS_GRANT] = granted_r;
        rd_nxt[STS_REFUSE] = refused_r;
        rd_nxt[STS_LOCK] = lock_r;
        rd_nxt[STS_ERASED] = erased_r;
        rd_nxt[STS_PROTECT] = prot_live;
        rd_nxt[STS_MATCH] = match_r;
        rd_nxt[STS_OVERPROG] = ovp_r;
        rd_nxt[STS_PAR_BLOCK] = par_block_r;
      end
      IDX_RXKEY_LO: rd_nxt = rx_key_r[31:0];
      IDX_RXKEY_HI: rd_nxt = {8'h00, rx_key_r[KEY_W-1:32]};
      default: begin
        if (slot != SL_NONE) begin
          rd_nxt = {24'h000000, flash_r[slot]};
        end else begin
          hit_nxt = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= setup;
      if (setup) begin
        pslverr_r <= !hit_nxt;
        prdata_r <= pwrite ? '0 : rd_nxt;
      end
    end
  end

  // received key, frozen while a check runs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_key_r <= '0;
    end else if (wr && state_r == ST_IDLE) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b] && idx == IDX_RXKEY_LO) begin
          rx_key_r[b*8 +: 8] <= pwdata[b*8 +: 8];
        end
      end
      // upper word holds only three key bytes
      for (int b = 0; b < 3; b++) begin
        if (pstrb[b] && idx == IDX_RXKEY_HI) begin
          rx_key_r[32 + b*8 +: 8] <= pwdata[b*8 +: 8];
        end
      end
    end
  end

  // flash image, non-volatile across sys_rst
  always_ff @(posedge clk) begin
    if (flash_init || state_r == ST_ERASE || (ctrl_wr && pwdata[CTRL_ERASE_BLK])) begin
      for (int s = 0; s < N_SLOTS; s++) begin
        flash_r[s] <= ERASED_BYTE; // see R1, R12
      end
    end else if (wr && slot != SL_NONE && pstrb[0] && state_r == ST_IDLE) begin
      flash_r[slot] <= flash_r[slot] & pwdata[7:0]; // see R13
    end
  end

  // reprogram without erase flagged; set beats clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ovp_r <= 1'b0;
    end else if (wr && slot != SL_NONE && pstrb[0] && state_r == ST_IDLE
                 && flash_r[slot] != ERASED_BYTE) begin
      ovp_r <= 1'b1; // see R13
    end else if (ctrl_wr && pwdata[CTRL_CLR_OVP]) begin
      ovp_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: if (cmp_start) state_r <= ST_CMP;
        ST_CMP: if (cmp_done) state_r <= ST_DECIDE;
        ST_DECIDE: state_r <= go_erase ? ST_ERASE : ST_IDLE;
        ST_ERASE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // outcome of a key check
  always_ff @(posedge clk) begin
    if (sys_rst || cmp_start) begin
      granted_r <= 1'b0;
      refused_r <= 1'b0;
      lock_r <= 1'b0;
      erased_r <= 1'b0;
      match_r <= 1'b0;
      erase_pulse_r <= 1'b0;
    end else begin
      erase_pulse_r <= (state_r == ST_DECIDE) && go_erase; // see R1, R2
      if (state_r == ST_DECIDE) begin
        match_r <= cmp_match;
        lock_r <= st_lock; // see R4
        if (!go_erase) begin
          granted_r <= !st_lock && (blank_vec || cmp_match); // see R3, R4, R15, R16
          refused_r <= st_lock || (!blank_vec && !cmp_match); // see R3, R16
        end
      end else if (state_r == ST_ERASE) begin
        granted_r <= 1'b1;
        erased_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      par_block_r <= 1'b0;
    end else begin
      par_block_r <= lock_r && prot_live; // see R5
    end
  end

  // option byte captured once after reset release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cap_pend_r <= 1'b1;
      wdt_auto_r <= 1'b0;
      csp_r <= 1'b0;
      vmon_r <= 1'b0;
      por_r <= 1'b0;
      vdet_r <= 2'h3;
      prot_r <= 1'b0;
    end else if (cap_pend_r) begin
      cap_pend_r <= 1'b0;
      wdt_auto_r <= !flash_r[SL_OPT][OPT_WDT_AUTO_N]; // see R6, R14
      prot_r <= flash_r[SL_OPT][OPT_PROT_DIS] && !flash_r[SL_OPT][OPT_PROT_N]; // see R7, R8
      vdet_r <= {flash_r[SL_OPT][OPT_VDET_HI], flash_r[SL_OPT][OPT_VDET_LO]}; // see R9
      vmon_r <= !flash_r[SL_OPT][OPT_VMON_DIS]; // see R10
      por_r <= !flash_r[SL_OPT][OPT_VMON_DIS]; // see R10
      csp_r <= !flash_r[SL_OPT][OPT_CSP_N]; // see R11
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign serial_access_grant = granted_r;
  assign serial_refused = refused_r;
  assign user_flash_erase = erase_pulse_r;
  assign parallel_prog_block = par_block_r;
  assign wdt_autostart = wdt_auto_r;
  assign count_src_protect_en = csp_r;
  assign vmon_reset_en = vmon_r;
  assign por_en = por_r;
  assign vdet_level = vdet_r;
  assign code_protect_en = prot_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_erase_both: assert property (state_r == ST_DECIDE && !st_lock && !blank_vec // see R1
    && rx_erase && st_erase |=> state_r == ST_ERASE ##1 granted_r && erased_r)
    else $error("both erase keywords did not erase");
  chk_erase_prot: assert property (state_r == ST_DECIDE && !st_lock && !blank_vec // see R2
    && rx_erase && !st_erase |=> (state_r == ST_ERASE) == !$past(prot_live))
    else $error("forced erase ignored protect pair");
  chk_stored_erase: assert property (state_r == ST_DECIDE && !st_lock && !blank_vec // see R3
    && st_erase && !rx_erase |=> refused_r && !granted_r && state_r == ST_IDLE)
    else $error("stored erase keyword not treated as mismatch");
  chk_lock_refuse: assert property (lock_r |-> !granted_r && refused_r) // see R4
    else $error("lockout key still granted access");
  chk_par_block: assert property (lock_r && prot_live ##1 lock_r |-> par_block_r) // see R5
    else $error("parallel block missing under lockout");
  chk_wdt_opt: assert property (cap_pend_r |=> wdt_autostart // see R6
    == !$past(flash_r[SL_OPT][OPT_WDT_AUTO_N]))
    else $error("watchdog start option not applied");
  chk_protect_opt: assert property (cap_pend_r |=> code_protect_en == // see R8
    ($past(flash_r[SL_OPT][OPT_PROT_DIS]) && !$past(flash_r[SL_OPT][OPT_PROT_N])))
    else $error("protect decode wrong");
  chk_vdet_opt: assert property (cap_pend_r |=> vdet_level == // see R9
    {$past(flash_r[SL_OPT][OPT_VDET_HI]), $past(flash_r[SL_OPT][OPT_VDET_LO])})
    else $error("voltage detect level not applied");
  chk_csp_opt: assert property (cap_pend_r |=> count_src_protect_en // see R11
    == !$past(flash_r[SL_OPT][OPT_CSP_N]))
    else $error("count source protect option not applied");
  chk_erase_ones: assert property (state_r == ST_ERASE |=> flash_r[SL_OPT] == ERASED_BYTE) // see R12
    else $error("erase left option byte not all ones");
  chk_blank_vec: assert property (state_r == ST_DECIDE && blank_vec && !st_lock // see R15
    |=> granted_r)
    else $error("blank reset vector not accepted");
  chk_mismatch: assert property (state_r == ST_DECIDE && !go_erase && !blank_vec // see R16
    && !cmp_match |=> refused_r && !granted_r)
    else $error("mismatched key not refused");
  chk_check_len: assert property (cmp_start |-> ##9 state_r == ST_DECIDE) // see R18
    else $error("check did not reach decision");

  cov_forced_erase: cover property (state_r == ST_ERASE);
  cov_lockout: cover property (lock_r && prot_live);
  cov_grant_match: cover property (state_r == ST_DECIDE && cmp_match && !blank_vec);
  cov_refuse: cover property ($rose(refused_r));
endmodule

// ---- hw/spg_key_cmp.sv ----
// Purpose: byte-serial compare of received key against stored key
// Assumes: both keys stay stable from start until done
// Notes: one key byte per cycle, done pulses eight cycles after start
`timescale 1ns/10ps
module spg_key_cmp import spg_pkg::*; #(
  parameter int NBYTES = KEY_BYTES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [KEY_W-1:0] rx_key,
  input wire logic [KEY_W-1:0] st_key,
  output logic done_r,
  output logic match_r,
  output logic rx_erase_r,
  output logic st_erase_r,
  output logic st_lock_r
);
  logic [2:0] pos_r;
  logic busy_r;
  logic last;

  assign last = (pos_r == 3'(NBYTES - 1));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pos_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= busy_r & last;
      if (start && !busy_r) begin
        busy_r <= 1'b1;
        pos_r <= '0;
      end else if (busy_r) begin
        pos_r <= last ? '0 : pos_r + 3'h1;
        busy_r <= !last;
      end
    end
  end

  // every position must agree
  always_ff @(posedge clk) begin
    if (sys_rst || (start && !busy_r)) begin
      match_r <= 1'b1;
      rx_erase_r <= 1'b1;
      st_erase_r <= 1'b1;
      st_lock_r <= 1'b1;
    end else if (busy_r) begin
      match_r <= match_r & (key_byte(rx_key, pos_r) == key_byte(st_key, pos_r)); // see R18
      rx_erase_r <= rx_erase_r & (key_byte(rx_key, pos_r) == key_byte(ERASE_KEYWORD, pos_r));
      st_erase_r <= st_erase_r & (key_byte(st_key, pos_r) == key_byte(ERASE_KEYWORD, pos_r)); // see R17
      st_lock_r <= st_lock_r & (key_byte(st_key, pos_r) == key_byte(LOCK_KEYWORD, pos_r)); // see R17
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_cmp_latency: assert property (start && !busy_r |-> ##8 done_r) // see R18
    else $error("key compare did not finish in eight cycles");
  chk_match_all: assert property (done_r |-> match_r == (rx_key == st_key)) // see R18
    else $error("match flag disagrees with full key compare");
  chk_keyword_seq: assert property (done_r |-> st_lock_r == (st_key == LOCK_KEYWORD) // see R17
    && st_erase_r == (st_key == ERASE_KEYWORD))
    else $error("stored keyword flags wrong");
endmodule

// ---- pkg/spg_pkg.sv ----
// Purpose: shared constants for the serial program access guard
// Assumes: register indices times four give the apb byte address
// Notes: key byte 1 sits in the low bits of every 56-bit key vector
package spg_pkg;
  localparam int APB_AW = 18;
  localparam int KEY_BYTES = 7;
  localparam int KEY_W = 56;

  // register indices
  localparam logic [15:0] IDX_CTRL = 16'h0000;
  localparam logic [15:0] IDX_STATUS = 16'h0001;
  localparam logic [15:0] IDX_RXKEY_LO = 16'h0002;
  localparam logic [15:0] IDX_RXKEY_HI = 16'h0003;
  localparam logic [15:0] IDX_OPT2 = 16'hffdb;
  localparam logic [15:0] IDX_KEY1 = 16'hffdf;
  localparam logic [15:0] IDX_KEY2 = 16'hffe3;
  localparam logic [15:0] IDX_KEY3 = 16'hffeb;
  localparam logic [15:0] IDX_KEY4 = 16'hffef;
  localparam logic [15:0] IDX_KEY5 = 16'hfff3;
  localparam logic [15:0] IDX_KEY6 = 16'hfff7;
  localparam logic [15:0] IDX_KEY7 = 16'hfffb;
  localparam logic [15:0] IDX_RVEC0 = 16'hfffc;
  localparam logic [15:0] IDX_RVEC1 = 16'hfffd;
  localparam logic [15:0] IDX_RVEC2 = 16'hfffe;
  localparam logic [15:0] IDX_OPT = 16'hffff;

  // flash image slots
  localparam logic [3:0] SL_KEY0 = 4'h0;
  localparam logic [3:0] SL_OPT = 4'h7;
  localparam logic [3:0] SL_OPT2 = 4'h8;
  localparam logic [3:0] SL_RVEC0 = 4'h9;
  localparam logic [3:0] SL_RVEC1 = 4'ha;
  localparam logic [3:0] SL_RVEC2 = 4'hb;
  localparam logic [3:0] SL_NONE = 4'hf;
  localparam int N_SLOTS = 12;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // option_select_byte fields
  localparam int OPT_WDT_AUTO_N = 0;
  localparam int OPT_PROT_DIS = 2;
  localparam int OPT_PROT_N = 3;
  localparam int OPT_VDET_LO = 4;
  localparam int OPT_VDET_HI = 5;
  localparam int OPT_VMON_DIS = 6;
  localparam int OPT_CSP_N = 7;
  // {protect_bit_n, protect_disable_ctl}
  localparam logic [1:0] PROT_ENABLED_PAIR = 2'h1;

  // control and status fields
  localparam int CTRL_START = 0;
  localparam int CTRL_ERASE_BLK = 1;
  localparam int CTRL_CLR_OVP = 2;
  localparam int STS_BUSY = 0;
  localparam int STS_GRANT = 1;
  localparam int STS_REFUSE = 2;
  localparam int STS_LOCK = 3;
  localparam int STS_ERASED = 4;
  localparam int STS_PROTECT = 5;
  localparam int STS_MATCH = 6;
  localparam int STS_OVERPROG = 7;
  localparam int STS_PAR_BLOCK = 8;

  localparam logic [KEY_W-1:0] ERASE_KEYWORD =
    {8'h45, 8'h53, 8'h41, 8'h52, 8'h65, 8'h4c, 8'h41};
  localparam logic [KEY_W-1:0] LOCK_KEYWORD =
    {8'h74, 8'h63, 8'h65, 8'h74, 8'h6f, 8'h72, 8'h50};

  typedef enum logic [1:0] {ST_IDLE, ST_CMP, ST_DECIDE, ST_ERASE} spg_state_t;

  function automatic logic [7:0] key_byte(input logic [KEY_W-1:0] k, input int i);
    key_byte = k[i*8 +: 8];
  endfunction

  function automatic logic [3:0] slot_of(input logic [15:0] idx);
    case (idx)
      IDX_KEY1: slot_of = 4'h0;
      IDX_KEY2: slot_of = 4'h1;
      IDX_KEY3: slot_of = 4'h2;
      IDX_KEY4: slot_of = 4'h3;
      IDX_KEY5: slot_of = 4'h4;
      IDX_KEY6: slot_of = 4'h5;
      IDX_KEY7: slot_of = 4'h6;
      IDX_OPT: slot_of = SL_OPT;
      IDX_OPT2: slot_of = SL_OPT2;
      IDX_RVEC0: slot_of = SL_RVEC0;
      IDX_RVEC1: slot_of = SL_RVEC1;
      IDX_RVEC2: slot_of = SL_RVEC2;
      default: slot_of = SL_NONE;
    endcase
  endfunction
endpackage

// ---- sim/spg_guard_tb.sv ----
// Purpose: self-checking bench for the access guard
// Assumes: apb answer within a few cycles, decision 10 cycles after start
// Notes: option outputs are checked after a reset following each image setup
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module spg_guard_tb import spg_pkg::*; ();
  typedef struct packed {
    logic [7:0] opt;
    logic [2:0] st;
    logic [2:0] rx;
    logic blank;
    logic [6:0] oexp;
    logic [3:0] dexp;
  } spg_row_t;
  logic clk = 1'b0, sys_rst = 1'b1, flash_init = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, opt_prog = 1'b0, img_erase = 1'b1;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] key_sel = 3'h0;
  logic [KEY_W-1:0] key;
  logic pready, pslverr, grant, refused, ufe, ppb, wdt, csp, vmon, por, cp, opt_blank_r;
  logic [1:0] vdet;
  int err_count = 0, comparisons = 0, erase_cnt = 0;
  logic [15:0] kidx [7] = '{IDX_KEY1, IDX_KEY2, IDX_KEY3, IDX_KEY4, IDX_KEY5, IDX_KEY6,
    IDX_KEY7};
  // opt, stored, received, blank vector, option outputs, {grant,refused,erase,par}
  spg_row_t rows [13] = '{
    '{8'hff, 3'h0, 3'h0, 1'b0, 7'h06, 4'ha}, '{8'hf6, 3'h0, 3'h0, 1'b0, 7'h47, 4'ha},
    '{8'h00, 3'h2, 3'h0, 1'b0, 7'h78, 4'ha}, '{8'ha5, 3'h2, 3'h0, 1'b0, 7'h1d, 4'h4},
    '{8'h4c, 3'h0, 3'h2, 1'b0, 7'h60, 4'h4}, '{8'hf6, 3'h1, 3'h1, 1'b0, 7'h47, 4'h5},
    '{8'h9b, 3'h1, 3'h1, 1'b0, 7'h1a, 4'h4}, '{8'hff, 3'h2, 3'h3, 1'b1, 7'h06, 4'h8},
    '{8'hff, 3'h2, 3'h2, 1'b0, 7'h06, 4'h8}, '{8'hff, 3'h2, 3'h3, 1'b0, 7'h06, 4'h4},
    '{8'hff, 3'h4, 3'h4, 1'b0, 7'h06, 4'h8}, '{8'hff, 3'h1, 3'h2, 1'b1, 7'h06, 4'h4},
    '{8'h9b, 3'h2, 3'h0, 1'b0, 7'h1a, 4'ha}};

  always #2.5 clk = ~clk;
  always @(posedge clk) if (ufe === 1'b1) erase_cnt <= erase_cnt + 1;

  spg_guard i_spg_guard (.clk(clk), .sys_rst(sys_rst), .flash_init(flash_init),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_access_grant(grant), .serial_refused(refused), .user_flash_erase(ufe),
    .parallel_prog_block(ppb), .wdt_autostart(wdt), .count_src_protect_en(csp),
    .vmon_reset_en(vmon), .por_en(por), .vdet_level(vdet), .code_protect_en(cp));

  spg_prog_model i_spg_prog_model (.clk(clk), .key_sel(key_sel), .opt_prog(opt_prog),
    .img_erase(img_erase), .key(key), .opt_blank_r(opt_blank_r));

  task automatic end_sim;
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // hold the request until pready is sampled high; the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] d);
    logic e;
    apb(1'b0, idx, 32'h0, d, e);
  endtask

  task automatic erase_img;
    wr(IDX_CTRL, 32'h2);
    img_erase <= 1'b1;
    @(posedge clk);
    img_erase <= 1'b0;
  endtask

  task automatic setup(input logic [7:0] opt, input logic [2:0] st, input logic [2:0] rx,
      input logic blank);
    if (opt_blank_r !== 1'b1) erase_img();
    wr(IDX_OPT, {24'h0, opt});
    opt_prog <= 1'b1;
    key_sel <= st;
    @(posedge clk);
    opt_prog <= 1'b0;
    for (int j = 0; j < KEY_BYTES; j++) wr(kidx[j], {24'h0, key[j*8 +: 8]});
    if (blank == 1'b0) wr(IDX_RVEC0, 32'h0);
    // reset clears the received key, so it is loaded after release
    sys_rst <= 1'b1;
    key_sel <= rx;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    wr(IDX_RXKEY_LO, key[31:0]);
    wr(IDX_RXKEY_HI, {8'h0, key[55:32]});
  endtask

  initial begin
    logic [31:0] r;
    logic e;
    int e0;
    repeat (7) @(posedge clk);
    @(negedge clk);
    `CHK("rst_opt", 7'h06, {wdt, csp, vmon, por, vdet, cp})
    `CHK("rst_bus", 38'h0, {grant, refused, ppb, ufe, pready, pslverr, prdata})
    @(posedge clk);
    sys_rst <= 1'b0;
    flash_init <= 1'b0;
    img_erase <= 1'b0;
    foreach (rows[i]) begin
      setup(rows[i].opt, rows[i].st, rows[i].rx, rows[i].blank);
      @(negedge clk);
      `CHK("options", rows[i].oexp, {wdt, csp, vmon, por, vdet, cp})
      e0 = erase_cnt;
      wr(IDX_CTRL, 32'h1);
      repeat (12) @(posedge clk);
      @(negedge clk);
      `CHK("decision", rows[i].dexp, {grant, refused, erase_cnt - e0 == 1, ppb})
      rd(IDX_STATUS, r);
      `CHK("lockout", rows[i].st == 3'h1, r[STS_LOCK])
      rd(IDX_OPT, r);
      `CHK("opt_img", rows[i].dexp[1] ? 32'hff : {24'h0, rows[i].opt}, r)
    end
    apb(1'b0, 16'h0010, 32'h0, r, e);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, r)
    // second start and key write while busy must be ignored
    setup(8'hff, 3'h2, 3'h2, 1'b0);
    wr(IDX_CTRL, 32'h1);
    wr(IDX_RXKEY_LO, 32'h0);
    wr(IDX_CTRL, 32'h1);
    repeat (5) @(posedge clk);
    @(negedge clk);
    `CHK("busy_grant", 2'h2, {grant, refused})
    rd(IDX_RXKEY_LO, r);
    `CHK("busy_rxkey", 32'h44556677, r)
    // deliberate double option write by the programmer
    wr(IDX_OPT, 32'h0f);
    wr(IDX_OPT, 32'hf0);
    rd(IDX_OPT, r);
    `CHK("overprog_val", 32'h0, r)
    rd(IDX_STATUS, r);
    `CHK("overprog_flag", 1'b1, r[STS_OVERPROG])
    wr(IDX_CTRL, 32'h4);
    rd(IDX_STATUS, r);
    `CHK("overprog_clr", 1'b0, r[STS_OVERPROG])
    erase_img();
    rd(IDX_OPT, r);
    `CHK("erased_opt", 32'hff, r)
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule

// ---- sim/spg_prog_model.sv ----
// Purpose: programmer side model, supplies received and stored keys
// Assumes: key_sel is set one clock before the key is used
// Notes: opt_blank_r says whether the option byte may be written once
`timescale 1ns/10ps
module spg_prog_model import spg_pkg::*; (
  input wire logic clk,
  input wire logic [2:0] key_sel,
  input wire logic opt_prog,
  input wire logic img_erase,
  output logic [KEY_W-1:0] key,
  output logic opt_blank_r
);
  always_comb begin
    case (key_sel)
      3'h0: key = ERASE_KEYWORD;
      3'h1: key = LOCK_KEYWORD;
      3'h2: key = 56'h11223344556677;
      3'h3: key = 56'h99223344556677;
      default: key = LOCK_KEYWORD ^ 56'h00000000000001;
    endcase
  end

  // erase first, then one option write
  always_ff @(posedge clk) begin
    if (img_erase) begin
      opt_blank_r <= 1'b1;
    end else if (opt_prog) begin
      opt_blank_r <= 1'b0;
    end
  end
endmodule
